// ---- aps_pkg.sv ----
// Register map, field layout, reset values and types of the sequencer
package aps_pkg;
  localparam int SETS = 8;
  localparam int IDX_W = 3;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FEAT = 8'h04;
  localparam logic [7:0] A_SETSEL = 8'h08;
  localparam logic [7:0] A_CMD = 8'h0C;
  localparam logic [7:0] A_PATH = 8'h10;
  localparam logic [7:0] A_START = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_VALID = 8'h1C;
  localparam logic [7:0] A_EXPO = 8'h20;
  localparam logic [7:0] A_GAIN = 8'h24;
  localparam logic [7:0] A_IMPL = 8'h28;
  localparam logic [7:0] A_FIXD = 8'h2C;
  localparam logic [7:0] A_AUTO = 8'h30;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CFG = 1;
  localparam int CMD_STORE = 0;
  localparam int CMD_APPLY = 1;
  localparam int CMD_ERASE = 2;
  localparam int STAT_OK = 8;
  localparam int STAT_STREAM = 9;
  localparam int SEL_OK = 8;
  localparam int PATH_NEXT = 4;
  localparam logic [15:0] EXPO_RST = 16'h0FA0;
  localparam logic [15:0] GAIN_RST = 16'h0001;
  localparam logic [15:0] IMPL_RST = 16'h0000;
  localparam logic [15:0] FIXD_RST = 16'h0000;
  localparam logic [15:0] GAIN_MAX = 16'h00FF;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_CFG = 2'b01,
    M_RUN = 2'b10
  } aps_mode_t;
  typedef enum logic [1:0] {
    SRC_FRAME = 2'b00,
    SRC_LINE0 = 2'b01,
    SRC_LINE1 = 2'b10,
    SRC_NONE = 2'b11
  } aps_src_t;
  typedef enum logic [1:0] {
    ACT_RISE = 2'b00,
    ACT_FALL = 2'b01,
    ACT_ANY = 2'b10,
    ACT_HIGH = 2'b11
  } aps_act_t;
  typedef struct packed {
    logic [15:0] expo;
    logic [15:0] gain;
    logic [15:0] impl;
  } aps_params_t;
  typedef struct packed {
    aps_src_t src;
    aps_act_t act;
    logic [2:0] next;
  } aps_path_t;
  localparam aps_path_t PATH_RST = '{SRC_FRAME, ACT_RISE, 3'h0};
endpackage

// ---- aps_set_slot.sv ----
// One stored parameter set with its transition path and check
module aps_set_slot import aps_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Commands
  input wire logic store,
  input wire logic erase,
  input wire logic path_we,
  input wire aps_path_t path_in,
  // Live settings to capture and compare against
  input wire aps_params_t cur_params,
  input wire logic [15:0] cur_fixed,
  input wire logic [1:0] cur_mask,
  // Stored contents
  output aps_params_t params,
  output aps_path_t path,
  output logic check_ok
);
  logic [15:0] fixed_snap;
  logic [1:0] mask_snap;
  logic saved;

  always_ff @(posedge clock) begin
    if (!reset_n || erase) begin
      saved <= 1'b0;
      params <= '0;
      fixed_snap <= '0;
      mask_snap <= '0;
    end else if (store) begin
      saved <= 1'b1;
      params <= cur_params;
      fixed_snap <= cur_fixed;
      mask_snap <= cur_mask;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      path <= PATH_RST;
    end else if (path_we) begin
      path <= path_in;
    end
  end

  // A set stays usable only while the fixed features and the enabled
  // feature list it was saved under still hold
  assign check_ok = saved && (params.expo != 16'h0000) &&
      (params.gain <= GAIN_MAX) && (fixed_snap == cur_fixed) &&
      (mask_snap == cur_mask);
endmodule

// ---- aps_event_detect.sv ----
// Selects the path's trigger source and qualifies its activation
module aps_event_detect import aps_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Sources
  input wire logic frame_start,
  input wire logic [1:0] line_in,
  // Path selection
  input wire aps_src_t src,
  input wire aps_act_t act,
  // Qualified event
  output logic hit
);
  logic [1:0] line_s1;
  logic [1:0] line_s2;
  logic [2:0] lv_q;
  logic [2:0] lv;
  logic now_v;
  logic was_v;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      line_s1 <= 2'h0;
      line_s2 <= 2'h0;
      lv_q <= 3'h0;
    end else begin
      line_s1 <= line_in;
      line_s2 <= line_s1;
      lv_q <= lv;
    end
  end

  assign lv = {line_s2, frame_start};

  always_comb begin
    now_v = 1'b0;
    was_v = 1'b0;
    if (src != SRC_NONE) begin
      now_v = lv[src];
      was_v = lv_q[src];
    end
  end

  always_comb begin
    hit = 1'b0;
    if (src != SRC_NONE) begin
      case (act)
        ACT_RISE: hit = now_v && !was_v;
        ACT_FALL: hit = !now_v && was_v;
        ACT_ANY: hit = now_v != was_v;
        default: hit = now_v;
      endcase
    end
  end
endmodule

// ---- aps_sequencer.sv ----
// Parameter-set sequencer: register port, feature locks, set stepping
//
// The register addresses and the plain strobed port were left to the implementer.
module aps_sequencer import aps_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [31:0] rdata,
  // Trigger sources and streaming state
  input wire logic frame_start,
  input wire logic [1:0] line_in,
  input wire logic streaming,
  // Live configuration
  output aps_params_t live,
  output logic [15:0] live_fixed,
  output logic auto_eff,
  output logic seq_active,
  output logic [2:0] current_set_index
);
  aps_mode_t mode;
  aps_mode_t next_mode;
  logic [1:0] seq_feature_on;
  logic [2:0] set_pick;
  logic [2:0] first_set_index;
  logic auto_mode;
  logic [7:0] set_ok;
  logic seq_config_ok;
  logic reeval;
  aps_params_t params_a [SETS];
  aps_path_t paths_a [SETS];
  logic [7:0] check_v;
  logic wr_ctrl, wr_feat, wr_sel, wr_cmd, wr_path, wr_start;
  logic wr_expo, wr_gain, wr_impl, wr_fixd, wr_auto;
  logic store_go, apply_go, erase_go, start_go, step_go, cfg_exit;
  logic hit, cfg_good;
  logic [2:0] cur_next;
  logic [2:0] ld_idx;
  aps_params_t ld;
  aps_path_t path_wr;
  logic [31:0] rd_val;

  // Write decode
  always_comb begin
    {wr_ctrl, wr_feat, wr_sel, wr_cmd, wr_path, wr_start} = '0;
    {wr_expo, wr_gain, wr_impl, wr_fixd, wr_auto} = '0;
    if (we && addr == A_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (we && addr == A_FEAT) begin
      wr_feat = 1'b1;
    end else if (we && addr == A_SETSEL) begin
      wr_sel = 1'b1;
    end else if (we && addr == A_CMD) begin
      wr_cmd = 1'b1;
    end else if (we && addr == A_PATH) begin
      wr_path = 1'b1;
    end else if (we && addr == A_START) begin
      wr_start = 1'b1;
    end else if (we && addr == A_EXPO) begin
      wr_expo = 1'b1;
    end else if (we && addr == A_GAIN) begin
      wr_gain = 1'b1;
    end else if (we && addr == A_IMPL) begin
      wr_impl = 1'b1;
    end else if (we && addr == A_FIXD) begin
      wr_fixd = 1'b1;
    end else if (we && addr == A_AUTO) begin
      wr_auto = 1'b1;
    end
  end

  // Mode control
  always_comb begin
    next_mode = mode;
    start_go = 1'b0;
    cfg_exit = 1'b0;
    case (mode)
      M_IDLE: begin
        if (wr_ctrl && wdata[CTRL_CFG]) begin
          next_mode = M_CFG;
        end else if (wr_ctrl && wdata[CTRL_RUN] && seq_config_ok &&
            !streaming) begin
          next_mode = M_RUN;
          start_go = 1'b1;
        end
      end
      M_CFG: begin
        if (wr_ctrl && !wdata[CTRL_CFG]) begin
          next_mode = M_IDLE;
          cfg_exit = 1'b1;
        end
      end
      M_RUN: begin
        if (wr_ctrl && !wdata[CTRL_RUN]) begin
          next_mode = M_IDLE;
        end
      end
      default: next_mode = M_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode <= M_IDLE;
      seq_active <= 1'b0;
      auto_eff <= 1'b0;
    end else begin
      mode <= next_mode;
      seq_active <= next_mode == M_RUN;
      auto_eff <= auto_mode && (next_mode != M_RUN);
    end
  end

  assign store_go = wr_cmd && wdata[CMD_STORE] && mode == M_CFG;
  assign apply_go = wr_cmd && wdata[CMD_APPLY] && set_ok[set_pick];
  assign erase_go = wr_cmd && wdata[CMD_ERASE] && mode != M_RUN;
  assign cur_next = paths_a[current_set_index].next;
  // Path word: source [1:0], activation [3:2], next set at PATH_NEXT
  assign path_wr = '{aps_src_t'(wdata[1:0]), aps_act_t'(wdata[3:2]),
      wdata[PATH_NEXT +: IDX_W]};
  // Run-off write wins over a trigger in the same cycle
  assign step_go = mode == M_RUN && hit && next_mode == M_RUN;

  // Storage for the eight sets
  genvar gi;
  generate
    for (gi = 0; gi < SETS; gi++) begin : g_slot
      aps_set_slot u_slot (
        .clock(clock),
        .reset_n(reset_n),
        .store(store_go && set_pick == 3'(gi)),
        .erase(erase_go),
        .path_we(wr_path && mode == M_CFG && set_pick == 3'(gi)),
        .path_in(path_wr),
        .cur_params(live),
        .cur_fixed(live_fixed),
        .cur_mask(seq_feature_on),
        .params(params_a[gi]),
        .path(paths_a[gi]),
        .check_ok(check_v[gi])
      );
    end
  endgenerate

  aps_event_detect u_evt (
    .clock(clock),
    .reset_n(reset_n),
    .frame_start(frame_start),
    .line_in(line_in),
    .src(paths_a[current_set_index].src),
    .act(paths_a[current_set_index].act),
    .hit(hit)
  );

  // Configuration registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      seq_feature_on <= 2'h0;
      set_pick <= 3'h0;
      first_set_index <= 3'h0;
    end else begin
      if (wr_feat && mode == M_IDLE) begin
        seq_feature_on <= wdata[1:0];
      end
      if (wr_sel) begin
        set_pick <= wdata[2:0];
      end
      if (wr_start && mode == M_CFG) begin
        first_set_index <= wdata[2:0];
      end
    end
  end

  // Set validity, recomputed for every set once the new contents settle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reeval <= 1'b0;
      set_ok <= 8'h00;
    end else begin
      reeval <= store_go;
      if (erase_go) begin
        set_ok <= 8'h00;
      end else if (reeval) begin
        set_ok <= check_v;
      end
    end
  end

  // Whole sequence: start set valid, every valid set leads to a valid set
  always_comb begin
    cfg_good = check_v[first_set_index];
    for (int i = 0; i < SETS; i++) begin
      if (check_v[i] && !check_v[paths_a[i].next]) begin
        cfg_good = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      seq_config_ok <= 1'b0;
    end else if (erase_go || next_mode == M_CFG) begin
      seq_config_ok <= 1'b0;
    end else if (cfg_exit) begin
      seq_config_ok <= cfg_good;
    end
  end

  // Source of a load: start beats step beats software load
  always_comb begin
    if (start_go) begin
      ld_idx = first_set_index;
    end else if (step_go) begin
      ld_idx = cur_next;
    end else begin
      ld_idx = set_pick;
    end
    ld = params_a[ld_idx];
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      current_set_index <= 3'h0;
    end else if (start_go) begin
      current_set_index <= first_set_index;
    end else if (step_go) begin
      current_set_index <= cur_next;
    end
  end

  // Live settings; sequenced ones locked while running
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      live <= '{EXPO_RST, GAIN_RST, IMPL_RST};
    end else if (start_go || step_go || apply_go) begin
      if (seq_feature_on[0]) begin
        live.expo <= ld.expo;
      end
      if (seq_feature_on[1]) begin
        live.gain <= ld.gain;
      end
      live.impl <= ld.impl;
    end else begin
      if (wr_expo && !(mode == M_RUN && seq_feature_on[0])) begin
        live.expo <= wdata[15:0];
      end
      if (wr_gain && !(mode == M_RUN && seq_feature_on[1])) begin
        live.gain <= wdata[15:0];
      end
      if (wr_impl && mode != M_RUN) begin
        live.impl <= wdata[15:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      live_fixed <= FIXD_RST;
      auto_mode <= 1'b0;
    end else begin
      if (wr_fixd && mode == M_IDLE) begin
        live_fixed <= wdata[15:0];
      end
      if (wr_auto && mode != M_RUN) begin
        auto_mode <= wdata[0];
      end
    end
  end

  // Read port; command register and unused addresses always read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (addr == A_CTRL) begin
      rd_val[CTRL_RUN] = mode == M_RUN;
      rd_val[CTRL_CFG] = mode == M_CFG;
    end else if (addr == A_FEAT) begin
      rd_val[1:0] = seq_feature_on;
    end else if (addr == A_SETSEL) begin
      rd_val[2:0] = set_pick;
      rd_val[SEL_OK] = set_ok[set_pick];
    end else if (addr == A_PATH) begin
      rd_val[1:0] = paths_a[set_pick].src;
      rd_val[3:2] = paths_a[set_pick].act;
      rd_val[PATH_NEXT +: IDX_W] = paths_a[set_pick].next;
    end else if (addr == A_START) begin
      rd_val[2:0] = first_set_index;
    end else if (addr == A_STAT) begin
      rd_val[2:0] = current_set_index;
      rd_val[STAT_OK] = seq_config_ok;
      rd_val[STAT_STREAM] = streaming;
    end else if (addr == A_VALID) begin
      rd_val[7:0] = set_ok;
    end else if (addr == A_EXPO) begin
      rd_val[15:0] = live.expo;
    end else if (addr == A_GAIN) begin
      rd_val[15:0] = live.gain;
    end else if (addr == A_IMPL) begin
      rd_val[15:0] = live.impl;
    end else if (addr == A_FIXD) begin
      rd_val[15:0] = live_fixed;
    end else if (addr == A_AUTO) begin
      rd_val[0] = auto_mode;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= re ? rd_val : 32'h0000_0000;
    end
  end

  // Checks
  sequence s_trig;
    mode == M_RUN && hit && next_mode == M_RUN;
  endsequence
  sequence s_moved;
    ##1 current_set_index == $past(cur_next);
  endsequence

  property p_fixed_lock;
    @(posedge clock) disable iff (!reset_n)
    (mode != M_IDLE && wr_fixd) |=> $stable(live_fixed);
  endproperty
  a_fixed_lock: assert property (p_fixed_lock)
    else $error("fixed feature changed while locked");

  property p_impl_lock;
    @(posedge clock) disable iff (!reset_n)
    (mode == M_RUN && !step_go && wr_impl) |=> $stable(live.impl);
  endproperty
  a_impl_lock: assert property (p_impl_lock)
    else $error("implied feature written while running");

  property p_forced;
    @(posedge clock) disable iff (!reset_n)
    mode == M_RUN |-> !auto_eff && seq_active;
  endproperty
  a_forced: assert property (p_forced)
    else $error("automatic feature active while running");

  property p_start;
    @(posedge clock) disable iff (!reset_n)
    start_go |=> current_set_index == $past(first_set_index) &&
        mode == M_RUN;
  endproperty
  a_start: assert property (p_start)
    else $error("start set not loaded on run");

  property p_step;
    @(posedge clock) disable iff (!reset_n)
    s_trig |-> s_moved;
  endproperty
  a_step: assert property (p_step)
    else $error("trigger did not step to next set");

  property p_erase;
    @(posedge clock) disable iff (!reset_n)
    erase_go |=> set_ok == 8'h00 && !seq_config_ok && check_v == 8'h00;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase left a set valid");

  property p_save;
    @(posedge clock) disable iff (!reset_n)
    store_go |-> ##2
        (set_ok == $past(check_v) || erase_go || $past(erase_go));
  endproperty
  a_save: assert property (p_save)
    else $error("set validity not updated after save");

  property p_off_hold;
    @(posedge clock) disable iff (!reset_n)
    $fell(seq_active) |-> live == $past(live);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("live configuration changed at run off");

  property p_run_gate;
    @(posedge clock) disable iff (!reset_n)
    start_go |-> seq_config_ok && !streaming && mode == M_IDLE;
  endproperty
  a_run_gate: assert property (p_run_gate)
    else $error("run accepted without valid configuration");
endmodule

// ---- tb_aps_sequencer.sv ----
// Self-checking testbench for the parameter-set sequencer
module tb_aps_sequencer import aps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock and reset
  logic clock;
  logic reset_n;
  // Register port
  logic [7:0] addr;
  logic [31:0] wdata;
  logic we;
  logic re;
  logic [31:0] rdata;
  // Sources and outputs
  logic frame_start;
  logic [1:0] line_in;
  logic streaming;
  aps_params_t live;
  logic [15:0] live_fixed;
  logic auto_eff;
  logic seq_active;
  logic [2:0] current_set_index;
  int n_fail;
  int compares;

  aps_sequencer u_aps_sequencer (
    .clock(clock),
    .reset_n(reset_n),
    .addr(addr),
    .wdata(wdata),
    .we(we),
    .re(re),
    .rdata(rdata),
    .frame_start(frame_start),
    .line_in(line_in),
    .streaming(streaming),
    .live(live),
    .live_fixed(live_fixed),
    .auto_eff(auto_eff),
    .seq_active(seq_active),
    .current_set_index(current_set_index)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clock);
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    re <= 1'b1;
    @(posedge clock);
    re <= 1'b0;
    #1;
    chk({16'h0000, rdata}, {16'h0000, exp}, "read data");
  endtask

  // Lets registered outputs of the last write land
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  // Waits a bounded time for the active set to become exp
  task automatic wait_set(input logic [2:0] exp);
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++) begin
      @(posedge clock);
      #1;
      if (current_set_index === exp) begin
        seen = 1'b1;
      end
    end
    if (!seen) begin
      n_fail++;
      $display("mismatch at %0t: set step timed out", $time);
      print_verdict();
    end
  endtask

  // Raises frame_start for one cycle and waits for the set to change
  task automatic frame_step(input logic [2:0] exp);
    @(posedge clock);
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    wait_set(exp);
  endtask

  task automatic t_reset_values();
    chk(live, {16'h0FA0, 16'h0001, 16'h0000}, "live after reset");
    chk({32'h0, live_fixed}, 48'h0, "fixed after reset");
    chk({45'h0, auto_eff, seq_active, 1'b0}, 48'h0, "flags after reset");
    rd_chk(A_STAT, 32'h0000_0000);
    rd_chk(A_VALID, 32'h0000_0000);
    rd_chk(8'h3C, 32'h0000_0000);
  endtask

  task automatic t_locks_in_config();
    wr(A_FEAT, 32'h0000_0003);
    wr(A_FIXD, 32'h0000_0055);
    wr(A_AUTO, 32'h0000_0001);
    wr(A_CTRL, 32'h0000_0002);
    rd_chk(A_CTRL, 32'h0000_0002);
    wr(A_FIXD, 32'h0000_00AA);
    wr(A_FEAT, 32'h0000_0000);
    wr(A_IMPL, 32'h0000_0012);
    wr(A_AUTO, 32'h0000_0000);
    settle();
    chk({32'h0, live_fixed}, 48'h55, "fixed in config");
    rd_chk(A_FIXD, 32'h0000_0055);
    rd_chk(A_FEAT, 32'h0000_0003);
    chk({32'h0, live.impl}, 48'h12, "implied in config");
    chk({47'h0, auto_eff}, 48'h0, "auto in config");
    wr(A_AUTO, 32'h0000_0001);
  endtask

  task automatic t_save_sets();
    wr(A_SETSEL, 32'h0000_0000);
    wr(A_EXPO, 32'h0000_0FA0);
    wr(A_GAIN, 32'h0000_0001);
    wr(A_PATH, 32'h0000_0010);
    wr(A_CMD, 32'h0000_0001);
    wr(A_SETSEL, 32'h0000_0001);
    wr(A_EXPO, 32'h0000_07D0);
    wr(A_GAIN, 32'h0000_0002);
    wr(A_IMPL, 32'h0000_0034);
    wr(A_PATH, 32'h0000_0000);
    wr(A_CMD, 32'h0000_0001);
    wr(A_SETSEL, 32'h0000_0002);
    wr(A_EXPO, 32'h0000_0000);
    wr(A_PATH, 32'h0000_0010);
    wr(A_CMD, 32'h0000_0001);
    settle();
    rd_chk(A_VALID, 32'h0000_0003);
    rd_chk(A_SETSEL, 32'h0000_0002);
    wr(A_SETSEL, 32'h0000_0000);
    rd_chk(A_SETSEL, 32'h0000_0100);
    rd_chk(A_PATH, 32'h0000_0010);
    wr(A_SETSEL, 32'h0000_000F);
    rd_chk(A_SETSEL, 32'h0000_0007);
    wr(A_START, 32'h0000_0000);
    rd_chk(A_START, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0000);
    settle();
    rd_chk(A_STAT, 32'h0000_0100);
  endtask

  task automatic t_run_and_step();
    @(posedge clock);
    streaming <= 1'b1;
    wr(A_CTRL, 32'h0000_0001);
    settle();
    chk({47'h0, seq_active}, 48'h0, "run while streaming");
    rd_chk(A_STAT, 32'h0000_0300);
    @(posedge clock);
    streaming <= 1'b0;
    wr(A_CTRL, 32'h0000_0001);
    settle();
    chk({47'h0, seq_active}, 48'h1, "run accepted");
    chk({45'h0, current_set_index}, 48'h0, "start set");
    chk(live, {16'h0FA0, 16'h0001, 16'h0012}, "start load");
    chk({47'h0, auto_eff}, 48'h0, "auto forced off");
    wr(A_EXPO, 32'h0000_0099);
    wr(A_IMPL, 32'h0000_0077);
    wr(A_FIXD, 32'h0000_0011);
    wr(A_SETSEL, 32'h0000_0001);
    settle();
    chk(live, {16'h0FA0, 16'h0001, 16'h0012}, "locked writes");
    chk({32'h0, live_fixed}, 48'h55, "fixed while running");
    rd_chk(A_SETSEL, 32'h0000_0101);
    frame_step(3'h1);
    #1;
    chk(live, {16'h07D0, 16'h0002, 16'h0034}, "step to set one");
    rd_chk(A_STAT, 32'h0000_0101);
    frame_step(3'h0);
    #1;
    chk(live, {16'h0FA0, 16'h0001, 16'h0012}, "step to set zero");
    frame_step(3'h1);
    wr(A_CTRL, 32'h0000_0000);
    settle();
    chk({47'h0, seq_active}, 48'h0, "run off");
    chk(live, {16'h07D0, 16'h0002, 16'h0034}, "last set stays");
    chk({47'h0, auto_eff}, 48'h1, "auto back on");
  endtask

  task automatic t_load_any_time();
    wr(A_SETSEL, 32'h0000_0000);
    wr(A_CMD, 32'h0000_0002);
    settle();
    chk(live, {16'h0FA0, 16'h0001, 16'h0012}, "load in idle");
    chk({45'h0, current_set_index}, 48'h1, "load keeps index");
    wr(A_SETSEL, 32'h0000_0002);
    wr(A_CMD, 32'h0000_0002);
    settle();
    chk(live, {16'h0FA0, 16'h0001, 16'h0012}, "invalid set load");
  endtask

  task automatic t_revalidate_and_erase();
    wr(A_FIXD, 32'h0000_0066);
    wr(A_CTRL, 32'h0000_0002);
    wr(A_SETSEL, 32'h0000_0003);
    wr(A_EXPO, 32'h0000_0005);
    wr(A_CMD, 32'h0000_0001);
    settle();
    rd_chk(A_VALID, 32'h0000_0008);
    wr(A_CMD, 32'h0000_0004);
    settle();
    rd_chk(A_VALID, 32'h0000_0000);
    rd_chk(A_SETSEL, 32'h0000_0003);
  endtask

  // Line sources: falling edge on line 0, any edge on line 1
  task automatic t_line_trigger();
    wr(A_SETSEL, 32'h0000_0004);
    wr(A_EXPO, 32'h0000_0100);
    wr(A_PATH, 32'h0000_0055);
    wr(A_CMD, 32'h0000_0001);
    wr(A_SETSEL, 32'h0000_0005);
    wr(A_EXPO, 32'h0000_0200);
    wr(A_PATH, 32'h0000_004A);
    wr(A_CMD, 32'h0000_0001);
    wr(A_START, 32'h0000_0004);
    wr(A_CTRL, 32'h0000_0000);
    settle();
    rd_chk(A_VALID, 32'h0000_0030);
    wr(A_CTRL, 32'h0000_0001);
    settle();
    chk({45'h0, current_set_index}, 48'h4, "start set four");
    chk(live, {16'h0100, 16'h0001, 16'h0012}, "set four live");
    @(posedge clock);
    line_in <= 2'b01;
    repeat (6) @(posedge clock);
    #1;
    chk({45'h0, current_set_index}, 48'h4, "rise ignored");
    @(posedge clock);
    line_in <= 2'b00;
    wait_set(3'h5);
    chk(live, {16'h0200, 16'h0001, 16'h0012}, "set five live");
    @(posedge clock);
    line_in <= 2'b10;
    wait_set(3'h4);
    wr(A_CTRL, 32'h0000_0000);
    settle();
    chk(live, {16'h0100, 16'h0001, 16'h0012}, "last set four");
  endtask

  initial begin
    n_fail = 0;
    compares = 0;
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    we = 1'b0;
    re = 1'b0;
    frame_start = 1'b0;
    line_in = 2'h0;
    streaming = 1'b0;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    t_reset_values();
    t_locks_in_config();
    t_save_sets();
    t_run_and_step();
    t_load_any_time();
    t_revalidate_and_erase();
    t_line_trigger();
    print_verdict();
  end
endmodule
